// ===== src/ssper_pkg.sv
package ssper_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned FLAG_W = 5;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] REG_CTRL2 = 12'h001;
   localparam logic [ADDR_W-1:0] REG_STAT1 = 12'h002;
   localparam logic [ADDR_W-1:0] REG_STAT2 = 12'h003;
   localparam logic [ADDR_W-1:0] REG_FLAGS = 12'h004;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam logic [DATA_W-1:0] STAT_RST = 16'h0000;
   localparam logic [DATA_W-1:0] FLAG_RST = 16'h0000;
   // ****************************************
   // control field positions
   // ****************************************
   localparam int unsigned B_ANC_SEL   = 7;
   localparam int unsigned B_REMAP_OFF = 4;
   localparam int unsigned B_SUM_OFF   = 3;
   localparam int unsigned B_CRC_OFF   = 2;
   localparam int unsigned B_LNUM_OFF  = 1;
   localparam int unsigned B_TRS_OFF   = 0;
   // ****************************************
   // status field positions
   // ****************************************
   localparam int unsigned B_VSTD   = 10;
   localparam int unsigned B_FFCRC  = 9;
   localparam int unsigned B_APCRC  = 8;
   localparam int unsigned B_CSUM_C = 6;
   localparam int unsigned B_CSUM_Y = 5;
   localparam int unsigned B_LCRC_C = 4;
   localparam int unsigned B_LCRC_Y = 3;
   localparam int unsigned B_LNUM   = 2;
   localparam int unsigned B_SAV    = 1;
   localparam int unsigned B_EAV    = 0;
   // ****************************************
   // input rate
   // ****************************************
   typedef enum logic [1:0] {
      SSPER_RATE_SD = 2'h0,
      SSPER_RATE_HD = 2'h1,
      SSPER_RATE_3G = 2'h2
   } ssper_rate_t;
endpackage

// ===== src/ssper_sticky.sv
`timescale 1ns/10ps
module ssper_sticky #(
   parameter int unsigned        WIDTH   = ssper_pkg::DATA_W,
   parameter logic [WIDTH-1:0]   RST_VAL = ssper_pkg::STAT_RST
) (
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   // events and clear
   input  wire logic [WIDTH-1:0] i_set,
   input  wire logic             i_clr,
   // held bits
   output logic      [WIDTH-1:0] o_bits
);
   import ssper_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] bits;
   } ssper_sticky_t;

   ssper_sticky_t    st_ff;
   ssper_sticky_t    nxt_st;
   logic [WIDTH-1:0] nxt_bits;

   // set beats a clear in the same cycle
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      assign nxt_bits[g] = i_set[g] | (st_ff.bits[g] & ~i_clr);
   end

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.bits = nxt_bits;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff.bits <= RST_VAL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_bits = st_ff.bits;
endmodule

// ===== src/ssper_edh_capture.sv
`timescale 1ns/10ps
module ssper_edh_capture (
   // clock and reset
   input  wire logic                         i_mclk,
   input  wire logic                         i_rst,
   // received packet
   input  wire logic                         i_packet_seen,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_anc_flags,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_field_flags,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_picture_flags,
   // flag word
   output logic      [ssper_pkg::DATA_W-1:0] o_word
);
   import ssper_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] word;
   } ssper_edh_t;

   ssper_edh_t st_ff;
   ssper_edh_t nxt_st;

   // flags held until the next packet replaces them
   always_comb begin
      nxt_st = st_ff;
      if (i_packet_seen) begin
         nxt_st.word = {1'b1, i_anc_flags, i_field_flags, i_picture_flags};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff.word <= FLAG_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_word = st_ff.word;
endmodule

// ===== src/ssper_regs.sv
`timescale 1ns/10ps
module ssper_regs #(
   parameter int unsigned ADDR_W = ssper_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                         i_mclk,
   input  wire logic                         i_rst,
   // host register port
   input  wire logic                         i_reg_cs,
   input  wire logic                         i_reg_we,
   input  wire logic [ADDR_W-1:0]            i_reg_addr,
   input  wire logic [ssper_pkg::DATA_W-1:0] i_reg_wdata,
   output logic      [ssper_pkg::DATA_W-1:0] o_reg_rdata,
   output logic                              o_reg_ack,
   // input format
   input  wire ssper_pkg::ssper_rate_t       i_rate,
   input  wire logic                         i_level_b,
   // stream 1 fault events
   input  wire logic                         i_video_standard_fault,
   input  wire logic                         i_full_field_crc_fault,
   input  wire logic                         i_active_picture_crc_fault,
   input  wire logic                         i_s1_chroma_anc_sum_fault,
   input  wire logic                         i_s1_luma_anc_sum_fault,
   input  wire logic                         i_s1_chroma_line_crc_fault,
   input  wire logic                         i_s1_luma_line_crc_fault,
   input  wire logic                         i_s1_line_no_fault,
   input  wire logic                         i_s1_start_active_fault,
   input  wire logic                         i_s1_end_active_fault,
   // stream 2 fault events
   input  wire logic                         i_s2_chroma_anc_sum_fault,
   input  wire logic                         i_s2_luma_anc_sum_fault,
   input  wire logic                         i_s2_chroma_line_crc_fault,
   input  wire logic                         i_s2_luma_line_crc_fault,
   input  wire logic                         i_s2_line_no_fault,
   input  wire logic                         i_s2_start_active_fault,
   input  wire logic                         i_s2_end_active_fault,
   // received check packet
   input  wire logic                         i_embedded_check_packet_seen,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_rx_anc_flags,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_rx_field_flags,
   input  wire logic [ssper_pkg::FLAG_W-1:0] i_rx_picture_flags,
   // stream 2 processing controls
   output logic                              o_anc_extract_stream_select,
   output logic                              o_s2_bad_word_remap_off,
   output logic                              o_s2_anc_sum_insert_off,
   output logic                              o_s2_line_crc_insert_off,
   output logic                              o_s2_line_no_insert_off,
   output logic                              o_s2_timing_ref_insert_off
);
   import ssper_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [DATA_W-1:0] rdata;
      logic              ack;
      logic              anc_sel;
      logic              remap_off;
      logic              sum_off;
      logic              crc_off;
      logic              lnum_off;
      logic              trs_off;
   } ssper_regs_t;

   ssper_regs_t       st_ff;
   ssper_regs_t       nxt_st;

   logic              wr_ctrl;
   logic              clr_stat1;
   logic              clr_stat2;
   logic              is_level_b;
   logic              hd_or_sd;
   logic              not_sd;
   logic [DATA_W-1:0] set_stat1;
   logic [DATA_W-1:0] set_stat2;
   logic [DATA_W-1:0] stat1;
   logic [DATA_W-1:0] stat2;
   logic [DATA_W-1:0] flags;
   logic [DATA_W-1:0] rd_mux;

   // ****************************************
   // access decode
   // ****************************************
   assign wr_ctrl   = i_reg_cs & i_reg_we & (i_reg_addr == REG_CTRL2);
   assign clr_stat1 = i_reg_cs & i_reg_we & (i_reg_addr == REG_STAT1);
   assign clr_stat2 = i_reg_cs & i_reg_we & (i_reg_addr == REG_STAT2);

   // ****************************************
   // format qualifiers
   // ****************************************
   assign is_level_b = (i_rate == SSPER_RATE_3G) & i_level_b;
   assign hd_or_sd   = (i_rate == SSPER_RATE_HD) | (i_rate == SSPER_RATE_SD);
   assign not_sd     = (i_rate != SSPER_RATE_SD);

   // ****************************************
   // fault event mapping
   // ****************************************
   always_comb begin
      set_stat1           = STAT_RST;
      set_stat1[B_VSTD]   = i_video_standard_fault & hd_or_sd;
      set_stat1[B_FFCRC]  = i_full_field_crc_fault;
      set_stat1[B_APCRC]  = i_active_picture_crc_fault;
      set_stat1[B_CSUM_C] = i_s1_chroma_anc_sum_fault;
      set_stat1[B_CSUM_Y] = i_s1_luma_anc_sum_fault;
      set_stat1[B_LCRC_C] = i_s1_chroma_line_crc_fault & not_sd;
      set_stat1[B_LCRC_Y] = i_s1_luma_line_crc_fault & not_sd;
      set_stat1[B_LNUM]   = i_s1_line_no_fault & not_sd;
      set_stat1[B_SAV]    = i_s1_start_active_fault;
      set_stat1[B_EAV]    = i_s1_end_active_fault;
   end

   always_comb begin
      set_stat2           = STAT_RST;
      set_stat2[B_CSUM_C] = i_s2_chroma_anc_sum_fault & is_level_b;
      set_stat2[B_CSUM_Y] = i_s2_luma_anc_sum_fault & is_level_b;
      set_stat2[B_LCRC_C] = i_s2_chroma_line_crc_fault & is_level_b;
      set_stat2[B_LCRC_Y] = i_s2_luma_line_crc_fault & is_level_b;
      set_stat2[B_LNUM]   = i_s2_line_no_fault & is_level_b;
      set_stat2[B_SAV]    = i_s2_start_active_fault & is_level_b;
      set_stat2[B_EAV]    = i_s2_end_active_fault & is_level_b;
   end

   // ****************************************
   // status and flag words
   // ****************************************
   ssper_sticky #(
      .WIDTH   (DATA_W),
      .RST_VAL (STAT_RST)
   ) u_stat1 (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (set_stat1),
      .i_clr  (clr_stat1),
      .o_bits (stat1)
   );

   ssper_sticky #(
      .WIDTH   (DATA_W),
      .RST_VAL (STAT_RST)
   ) u_stat2 (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (set_stat2),
      .i_clr  (clr_stat2),
      .o_bits (stat2)
   );

   ssper_edh_capture u_flags (
      .i_mclk          (i_mclk),
      .i_rst           (i_rst),
      .i_packet_seen   (i_embedded_check_packet_seen),
      .i_anc_flags     (i_rx_anc_flags),
      .i_field_flags   (i_rx_field_flags),
      .i_picture_flags (i_rx_picture_flags),
      .o_word          (flags)
   );

   // ****************************************
   // read data select
   // ****************************************
   always_comb begin
      case (i_reg_addr)
         REG_CTRL2: begin
            rd_mux = {{(DATA_W-CTRL_W){1'b0}}, st_ff.ctrl};
         end
         REG_STAT1: begin
            rd_mux = stat1;
         end
         REG_STAT2: begin
            rd_mux = stat2;
         end
         REG_FLAGS: begin
            rd_mux = flags;
         end
         default: begin
            rd_mux = STAT_RST;
         end
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.ack = i_reg_cs;
      if (wr_ctrl) begin
         nxt_st.ctrl = i_reg_wdata[CTRL_W-1:0];
      end
      // read returns a snapshot, no side effect
      if (i_reg_cs && !i_reg_we) begin
         nxt_st.rdata = rd_mux;
      end
      // controls only take effect on level B input
      nxt_st.anc_sel   = st_ff.ctrl[B_ANC_SEL] & is_level_b;
      nxt_st.remap_off = st_ff.ctrl[B_REMAP_OFF] & is_level_b;
      nxt_st.sum_off   = st_ff.ctrl[B_SUM_OFF] & is_level_b;
      nxt_st.crc_off   = st_ff.ctrl[B_CRC_OFF] & is_level_b;
      nxt_st.lnum_off  = st_ff.ctrl[B_LNUM_OFF] & is_level_b;
      nxt_st.trs_off   = st_ff.ctrl[B_TRS_OFF] & is_level_b;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff.ctrl      <= CTRL_RST;
         st_ff.rdata     <= STAT_RST;
         st_ff.ack       <= 1'b0;
         st_ff.anc_sel   <= 1'b0;
         st_ff.remap_off <= 1'b0;
         st_ff.sum_off   <= 1'b0;
         st_ff.crc_off   <= 1'b0;
         st_ff.lnum_off  <= 1'b0;
         st_ff.trs_off   <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_reg_rdata                 = st_ff.rdata;
   assign o_reg_ack                   = st_ff.ack;
   assign o_anc_extract_stream_select = st_ff.anc_sel;
   assign o_s2_bad_word_remap_off     = st_ff.remap_off;
   assign o_s2_anc_sum_insert_off     = st_ff.sum_off;
   assign o_s2_line_crc_insert_off    = st_ff.crc_off;
   assign o_s2_line_no_insert_off     = st_ff.lnum_off;
   assign o_s2_timing_ref_insert_off  = st_ff.trs_off;
endmodule

// ===== dv/ssper_regs_chk.sv
`timescale 1ns/10ps
module ssper_regs_chk
   import ssper_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              i_mclk,
   input wire logic              i_rst,
   input wire logic              i_reg_cs,
   input wire logic              i_reg_we,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [15:0]       o_reg_rdata,
   input wire logic              o_reg_ack,
   input wire ssper_rate_t       i_rate,
   input wire logic              i_level_b,
   input wire logic              i_video_standard_fault,
   input wire logic              i_embedded_check_packet_seen,
   input wire logic [4:0]        i_rx_anc_flags,
   input wire logic [4:0]        i_rx_field_flags,
   input wire logic [4:0]        i_rx_picture_flags,
   input wire logic              o_anc_extract_stream_select,
   input wire logic              o_s2_bad_word_remap_off
);
   wire logic rd = i_reg_cs && !i_reg_we;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_ack_follows: assert property (i_reg_cs |=> o_reg_ack)
      else $error("ack missing after access");
   a_rdata_hold: assert property (!rd |=> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   a_sel_gate: assert property (o_anc_extract_stream_select |->
      $past(i_level_b) && $past(i_rate) == SSPER_RATE_3G) else $error("select outside level b");
   a_remap_gate: assert property (o_s2_bad_word_remap_off |->
      $past(i_level_b) && $past(i_rate) == SSPER_RATE_3G) else $error("remap off outside level b");
   a_std_sticky: assert property (i_video_standard_fault && i_rate != SSPER_RATE_3G
      ##1 rd && i_reg_addr == REG_STAT1 |=> o_reg_rdata[10]) else $error("standard fault lost");
   a_flag_word: assert property (i_embedded_check_packet_seen ##1 rd &&
      i_reg_addr == REG_FLAGS && !i_embedded_check_packet_seen |=> o_reg_rdata ==
      {1'b1, $past(i_rx_anc_flags, 2), $past(i_rx_field_flags, 2), $past(i_rx_picture_flags, 2)})
      else $error("flag word wrong");
   a_unmapped_zero: assert property (rd && i_reg_addr == 12'h000 |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_clear_stat: assert property (i_reg_cs && i_reg_we && i_reg_addr == REG_STAT2 &&
      !(i_level_b && i_rate == SSPER_RATE_3G) ##1 rd && i_reg_addr == REG_STAT2
      |=> o_reg_rdata == 16'h0000) else $error("status not cleared by write");
   c_ctrl_write: cover property (i_reg_cs && i_reg_we && i_reg_addr == REG_CTRL2);
   c_packet: cover property (i_embedded_check_packet_seen);
   c_remap_off: cover property (o_s2_bad_word_remap_off);
endmodule
bind ssper_regs ssper_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_reg_cs(i_reg_cs), .i_reg_we(i_reg_we), .i_reg_addr(i_reg_addr),
   .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .i_rate(i_rate), .i_level_b(i_level_b),
   .i_video_standard_fault(i_video_standard_fault),
   .i_embedded_check_packet_seen(i_embedded_check_packet_seen),
   .i_rx_anc_flags(i_rx_anc_flags), .i_rx_field_flags(i_rx_field_flags),
   .i_rx_picture_flags(i_rx_picture_flags),
   .o_anc_extract_stream_select(o_anc_extract_stream_select),
   .o_s2_bad_word_remap_off(o_s2_bad_word_remap_off));

// ===== dv/ssper_regs_tb.sv
`timescale 1ns/10ps
module ssper_regs_tb;
   import ssper_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        cs = 1'b0;
   logic        we = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic        ack;
   ssper_rate_t rate = SSPER_RATE_SD;
   logic        lvb = 1'b0;
   logic [9:0]  ev1 = 10'h000;
   logic [6:0]  ev2 = 7'h00;
   logic        pkt = 1'b0;
   logic [4:0]  fa = 5'h00;
   logic [4:0]  ff = 5'h00;
   logic [4:0]  fp = 5'h00;
   wire  [5:0]  ctl;
   logic [15:0] got, v, e1, e2, fw;
   int          failures = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          seed = 42686;
   ssper_regs DUT (.i_mclk(mclk), .i_rst(rst), .i_reg_cs(cs), .i_reg_we(we), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack), .i_rate(rate),
      .i_level_b(lvb), .i_video_standard_fault(ev1[9]), .i_full_field_crc_fault(ev1[8]),
      .i_active_picture_crc_fault(ev1[7]), .i_s1_chroma_anc_sum_fault(ev1[6]),
      .i_s1_luma_anc_sum_fault(ev1[5]), .i_s1_chroma_line_crc_fault(ev1[4]),
      .i_s1_luma_line_crc_fault(ev1[3]), .i_s1_line_no_fault(ev1[2]),
      .i_s1_start_active_fault(ev1[1]), .i_s1_end_active_fault(ev1[0]),
      .i_s2_chroma_anc_sum_fault(ev2[6]), .i_s2_luma_anc_sum_fault(ev2[5]),
      .i_s2_chroma_line_crc_fault(ev2[4]), .i_s2_luma_line_crc_fault(ev2[3]),
      .i_s2_line_no_fault(ev2[2]), .i_s2_start_active_fault(ev2[1]),
      .i_s2_end_active_fault(ev2[0]), .i_embedded_check_packet_seen(pkt),
      .i_rx_anc_flags(fa), .i_rx_field_flags(ff), .i_rx_picture_flags(fp),
      .o_anc_extract_stream_select(ctl[5]), .o_s2_bad_word_remap_off(ctl[4]),
      .o_s2_anc_sum_insert_off(ctl[3]), .o_s2_line_crc_insert_off(ctl[2]),
      .o_s2_line_no_insert_off(ctl[1]), .o_s2_timing_ref_insert_off(ctl[0]));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic final_report();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         final_report();
      end
   end
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // one access from a falling edge; strobe stays up for back to back use
   task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
      cs = 1'b1;
      we = w;
      addr = a;
      wdata = d;
      @(negedge mclk);
      got = rdata;
      chk(16'h0001, {15'h0000, ack});
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk(e, got);
   endtask
   function automatic logic lb();
      return rate == SSPER_RATE_3G && lvb;
   endfunction
   function automatic logic [15:0] s1exp(input logic [9:0] e);
      return {5'h00, e[9] & (rate != SSPER_RATE_3G), e[8:7], 1'b0, e[6:5],
              e[4:2] & {3{rate != SSPER_RATE_SD}}, e[1:0]};
   endfunction
   task automatic pick_rate();
      rate = ssper_rate_t'(2'($unsigned($random(seed)) % 3));
      lvb = 1'($random(seed));
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      for (int a = 0; a < 6; a++) begin
         rd(12'(a), 16'h0000);
      end
      for (int i = 0; i < 12; i++) begin
         if (i < 4) begin
            rate = SSPER_RATE_3G;
            lvb = 1'b1;
         end else begin
            pick_rate();
         end
         v = (i == 0) ? 16'hFFFF : 16'($random(seed));
         acc(1'b1, REG_CTRL2, v);
         rd(REG_CTRL2, {8'h00, v[7:0]});
         chk({10'h000, {v[7], v[4:0]} & {6{lb()}}}, {10'h000, ctl});
      end
      for (int i = 0; i < 18; i++) begin
         pick_rate();
         ev1 = 10'($random(seed));
         ev2 = 7'($random(seed));
         e1 = s1exp(ev1);
         e2 = lb() ? {9'h000, ev2} : 16'h0000;
         cs = 1'b0;
         @(negedge mclk);
         ev1 = 10'h000;
         ev2 = 7'h00;
         rd(REG_STAT1, e1);
         rd(REG_STAT1, e1);
         rd(REG_STAT2, e2);
         ev1 = 10'($random(seed));
         e1 = s1exp(ev1);
         acc(1'b1, REG_STAT1, 16'($random(seed)));
         ev1 = 10'h000;
         acc(1'b1, REG_STAT2, 16'h0000);
         rd(REG_STAT2, 16'h0000);
         rd(REG_STAT1, e1);
         acc(1'b1, REG_STAT1, 16'h0000);
      end
      for (int i = 0; i < 6; i++) begin
         fa = 5'($random(seed));
         ff = 5'($random(seed));
         fp = 5'($random(seed));
         fw = {1'b1, fa, ff, fp};
         pkt = 1'b1;
         cs = 1'b0;
         @(negedge mclk);
         pkt = 1'b0;
         fa = ~fa;
         rd(REG_FLAGS, fw);
         acc(1'b1, REG_FLAGS, 16'h0000);
         acc(1'b1, 12'h000, 16'hFFFF);
         rd(REG_FLAGS, fw);
         rd(12'h000, 16'h0000);
      end
      final_report();
   end
endmodule
